//--- verilog/page_mmu_regs.vh
// Constants for the paged memory ring protection unit.
// Included by the design modules; definitions only.
`ifndef PAGE_MMU_REGS_VH
`define PAGE_MMU_REGS_VH

// AXI4-Lite byte offsets
`define MMU_CTRL_OFF 12'h000
`define MMU_RING_OFF 12'h004
`define MMU_VIOL_OFF 12'h008
`define MMU_VADDR_OFF 12'h00c
`define MMU_TSEL_OFF 12'h010
`define MMU_PT_BASE 12'h400
`define MMU_PT_LAST 12'h7fc

// Status word fields
`define STATUS_MM_ON_BIT 14
`define STATUS_RESET 16'h0000

// Page table entry fields
`define PTE_WPM_BIT 15
`define PTE_RPM_BIT 14
`define PTE_FPM_BIT 13
`define PTE_RING_HI 10
`define PTE_RING_LO 9
`define PTE_PAGE_HI 7
`define PTE_PAGE_LO 0
`define PTE_RESET 16'h0000

// Violation code bits
`define VIOL_READ 0
`define VIOL_WRITE 1
`define VIOL_FETCH 2
`define VIOL_RING 3
`define VIOL_PRIV 4

// Internal status interrupts go to this program level
`define INT_LEVEL 4'he

// Access types
`define ACC_READ 2'h0
`define ACC_WRITE 2'h1
`define ACC_FETCH 2'h2

`endif

//--- verilog/page_table_store.v
// Four page index tables of 64 sixteen-bit entries in flip-flops.
// Assumes one write port from the register bus and two lookup indexes.
`timescale 1ns/10ps
`include "page_mmu_regs.vh"

module page_table_store
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Write port
  input wire wr_en,
  input wire [7:0] wr_idx,
  input wire [15:0] wr_data,
  // Lookup ports
  input wire [7:0] rd_idx,
  output wire [15:0] rd_data,
  input wire [7:0] bus_idx,
  output wire [15:0] bus_data
);

  reg [15:0] entry_r [0:255];
  integer i;

  // Entries held in registers so a lookup needs no memory cycle
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 256; i = i + 1)
        entry_r[i] <= `PTE_RESET; // [RULE_04]
    end
    else if (wr_en)
      entry_r[wr_idx] <= wr_data; // [RULE_03]
  end

  assign rd_data = entry_r[rd_idx];
  assign bus_data = entry_r[bus_idx];

endmodule // page_table_store

//--- verilog/access_check.v
// Combinational permission and ring check for one access.
// Assumes the page entry and current ring are already selected.
`timescale 1ns/10ps
`include "page_mmu_regs.vh"

module access_check
(
  // Access
  input wire [1:0] acc_type,
  input wire priv_instr,
  input wire [1:0] cur_ring,
  input wire [15:0] pte,
  // Result
  output reg [4:0] viol
);

  wire [1:0] page_ring;

  assign page_ring = pte[`PTE_RING_HI:`PTE_RING_LO];

  always @*
  begin
    viol = 5'h00;
    // Per-page permissions, checked apart from the ring
    if (acc_type == `ACC_READ && !pte[`PTE_RPM_BIT])
      viol[`VIOL_READ] = 1'b1; // [RULE_05]
    if (acc_type == `ACC_WRITE && !pte[`PTE_WPM_BIT])
      viol[`VIOL_WRITE] = 1'b1; // [RULE_05]
    if (acc_type == `ACC_FETCH && !pte[`PTE_FPM_BIT])
      viol[`VIOL_FETCH] = 1'b1; // [RULE_05]
    // Higher page ring than the running ring is refused
    if (page_ring > cur_ring)
      viol[`VIOL_RING] = 1'b1; // [RULE_09] [RULE_11]
    // Rings 0 and 1 may not run privileged instructions
    if (priv_instr && !cur_ring[1])
      viol[`VIOL_PRIV] = 1'b1; // [RULE_08]
  end

endmodule // access_check

//--- verilog/page_mmu.v
// Paged memory management unit with page and ring protection.
// Assumes a CPU issuing one access at a time and an AXI4-Lite master.
`timescale 1ns/10ps
`include "page_mmu_regs.vh"

// Contract
// RULE_01: Map every 16-bit virtual address to an 18-bit physical address.
// RULE_02: Pages are 1024 words; low ten address bits pass as offset.
// RULE_03: Four page tables of 64 entries, each maps full 64K space.
// RULE_04: Page entries live in 16-bit on-chip registers, no memory cycle.
// RULE_05: Read, write, fetch permission per page; denied types are blocked.
// RULE_06: Each page belongs to ring 0 to 3; ring 3 is highest.
// RULE_07: Running ring is the ring of the page of the fetched instruction.
// RULE_08: Rings 2 and 3 run everything; rings 0 and 1 refuse privileged ops.
// RULE_09: Access to same or lower ring allowed; higher ring refused.
// RULE_10: Refused access or privileged op is suppressed and raises an interrupt.
// RULE_11: Access proceeds only if both permission and ring checks pass.
// RULE_12: Internal status interrupts request program level 14.
// RULE_13: Status word bit 14 shows memory management on.
// RULE_14: With management off, addresses pass through zero-extended, unchecked.
module page_mmu
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // CPU access request
  input wire cpu_req,
  input wire [15:0] cpu_vaddr,
  input wire [1:0] cpu_acc_type,
  input wire cpu_priv_instr,
  // CPU access answer
  output reg cpu_ack,
  output reg cpu_grant,
  output reg [17:0] cpu_paddr,
  // Program level interrupt request
  output reg int_req,
  output reg [3:0] int_level,
  // Status
  output reg [1:0] cur_ring_out,
  output reg mem_mgmt_on_flag
);

  reg [15:0] cpu_status_word_r;
  reg [1:0] tbl_sel_r;
  reg [1:0] cur_ring_r;
  reg [4:0] viol_r;
  reg [15:0] viol_vaddr_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [11:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire [15:0] pte;
  wire [15:0] bus_pte;
  wire [4:0] viol;
  wire [7:0] pt_rd_idx;
  wire [7:0] bus_rd_idx;
  wire pt_wr_en;
  wire wr_fire;
  wire rd_fire;
  wire mm_on;
  wire blocked;
  wire [17:0] paddr_nxt;
  wire [1:0] ring_for_check;
  wire [31:0] wr_word;
  reg [31:0] old_word;
  reg [31:0] rd_word;

  // Table index: selected table in the high bits, page number below
  function [7:0] pt_index;
    input [1:0] tbl;
    input [5:0] page;
    begin
      pt_index = {tbl, page};
    end
  endfunction

  // Bus offset inside the page table window
  function [7:0] bus_pt_index;
    input [11:0] addr;
    begin
      bus_pt_index = addr[9:2];
    end
  endfunction

  // Merge byte lanes into an old word
  function [31:0] merge_bytes;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      merge_bytes = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge_bytes[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  function is_pt_addr;
    input [11:0] addr;
    begin
      is_pt_addr = (addr >= `MMU_PT_BASE) && (addr <= `MMU_PT_LAST);
    end
  endfunction

  // Any address that a read answers with OKAY
  function is_reg_addr;
    input [11:0] addr;
    begin
      is_reg_addr = (addr == `MMU_CTRL_OFF) || (addr == `MMU_RING_OFF) ||
        (addr == `MMU_VIOL_OFF) || (addr == `MMU_VADDR_OFF) ||
        (addr == `MMU_TSEL_OFF) || is_pt_addr(addr);
    end
  endfunction

  assign mm_on = cpu_status_word_r[`STATUS_MM_ON_BIT]; // [RULE_13]
  assign pt_rd_idx = pt_index(tbl_sel_r, cpu_vaddr[15:10]); // [RULE_03]
  assign bus_rd_idx = wr_fire ? bus_pt_index(aw_addr_r) : bus_pt_index(s_axi_araddr);

  page_table_store u_store
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(pt_wr_en),
    .wr_idx(bus_pt_index(aw_addr_r)),
    .wr_data(wr_word[15:0]),
    .rd_idx(pt_rd_idx),
    .rd_data(pte),
    .bus_idx(bus_rd_idx),
    .bus_data(bus_pte)
  );

  // A fetch is checked against the ring of the page it comes from
  assign ring_for_check = (cpu_acc_type == `ACC_FETCH) ?
    pte[`PTE_RING_HI:`PTE_RING_LO] : cur_ring_r; // [RULE_07]

  access_check u_check
  (
    .acc_type(cpu_acc_type),
    .priv_instr(cpu_priv_instr),
    .cur_ring(ring_for_check),
    .pte(pte),
    .viol(viol)
  );

  assign blocked = mm_on && (viol != 5'h00); // [RULE_11] [RULE_14]
  // Physical page from the entry, offset kept
  assign paddr_nxt = mm_on ? {pte[`PTE_PAGE_HI:`PTE_PAGE_LO], cpu_vaddr[9:0]} :
    {2'h0, cpu_vaddr}; // [RULE_01] [RULE_02] [RULE_14]

  // CPU side: one-cycle answer to each request
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_ack <= 1'b0;
      cpu_grant <= 1'b0;
      cpu_paddr <= 18'h00000;
      cur_ring_r <= 2'h0;
      int_req <= 1'b0;
      int_level <= 4'h0;
      viol_r <= 5'h00;
      viol_vaddr_r <= 16'h0000;
    end
    else
    begin
      cpu_ack <= cpu_req;
      cpu_grant <= cpu_req && !blocked; // [RULE_10]
      cpu_paddr <= (cpu_req && !blocked) ? paddr_nxt : 18'h00000; // [RULE_10]
      int_req <= cpu_req && blocked; // [RULE_10]
      int_level <= (cpu_req && blocked) ? `INT_LEVEL : 4'h0; // [RULE_12]
      if (cpu_req && !blocked && cpu_acc_type == `ACC_FETCH && mm_on)
        cur_ring_r <= pte[`PTE_RING_HI:`PTE_RING_LO]; // [RULE_06] [RULE_07]
      if (cpu_req && blocked)
      begin
        viol_r <= viol;
        viol_vaddr_r <= cpu_vaddr;
      end
      else if (wr_fire && aw_addr_r == `MMU_VIOL_OFF)
        viol_r <= 5'h00;
    end
  end

  // Register bus
  // A read that owns the table's bus port this cycle holds a write back by one
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid && !rd_fire;
  // Old value under a write, for byte-lane merging
  always @*
  begin
    if (aw_addr_r == `MMU_CTRL_OFF)
      old_word = {16'h0000, cpu_status_word_r};
    else if (aw_addr_r == `MMU_TSEL_OFF)
      old_word = {30'h0, tbl_sel_r};
    else
      old_word = {16'h0000, bus_pte};
  end
  assign wr_word = merge_bytes(old_word, w_data_r, w_strb_r);
  assign pt_wr_en = wr_fire && is_pt_addr(aw_addr_r);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always @*
  begin
    if (s_axi_araddr == `MMU_CTRL_OFF)
      rd_word = {16'h0000, cpu_status_word_r};
    else if (s_axi_araddr == `MMU_RING_OFF)
      rd_word = {30'h0, cur_ring_r};
    else if (s_axi_araddr == `MMU_VIOL_OFF)
      rd_word = {27'h0, viol_r};
    else if (s_axi_araddr == `MMU_VADDR_OFF)
      rd_word = {16'h0000, viol_vaddr_r};
    else if (s_axi_araddr == `MMU_TSEL_OFF)
      rd_word = {30'h0, tbl_sel_r};
    else if (is_pt_addr(s_axi_araddr))
      rd_word = {16'h0000, bus_pte};
    else
      rd_word = 32'h0;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      cpu_status_word_r <= `STATUS_RESET;
      tbl_sel_r <= 2'h0;
      cur_ring_out <= 2'h0;
      mem_mgmt_on_flag <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_r && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_hold_r && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == `MMU_CTRL_OFF)
        begin
          cpu_status_word_r <= wr_word[15:0]; // [RULE_13]
          s_axi_bresp <= 2'h0;
        end
        else if (aw_addr_r == `MMU_TSEL_OFF)
        begin
          tbl_sel_r <= wr_word[1:0];
          s_axi_bresp <= 2'h0;
        end
        else if (aw_addr_r == `MMU_VIOL_OFF || is_pt_addr(aw_addr_r))
          s_axi_bresp <= 2'h0;
        else
          s_axi_bresp <= 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        if (is_reg_addr(s_axi_araddr))
          s_axi_rresp <= 2'h0;
        else
          s_axi_rresp <= 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      cur_ring_out <= cur_ring_r;
      mem_mgmt_on_flag <= cpu_status_word_r[`STATUS_MM_ON_BIT]; // [RULE_13]
    end
  end

endmodule // page_mmu

//--- tb/page_mmu_asserts.sv
// Checker on the CPU side of page_mmu.
// Assumes the bind at the foot of this file.
`timescale 1ns/10ps
module page_mmu_asserts
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // CPU port and interrupt
  input wire cpu_req,
  input wire [15:0] cpu_vaddr,
  input wire cpu_ack,
  input wire cpu_grant,
  input wire [17:0] cpu_paddr,
  input wire int_req,
  input wire [3:0] int_level,
  input wire mem_mgmt_on_flag
);
  logic [15:0] va_q;
  always @(posedge sys_clk)
  begin
    va_q <= cpu_vaddr;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_ack;
    cpu_req |=> cpu_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_idle;
    !cpu_req |=> !cpu_ack;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without access");
  property p_off;
    cpu_req && !mem_mgmt_on_flag ##1 !mem_mgmt_on_flag |-> cpu_grant && cpu_paddr == {2'b00, va_q};
  endproperty
  a_off: assert property (p_off) else $error("not passed through");
  property p_ofs;
    cpu_grant |-> cpu_paddr[9:0] == va_q[9:0];
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset changed");
  property p_one;
    cpu_grant |-> cpu_ack && !int_req;
  endproperty
  a_one: assert property (p_one) else $error("grant with violation");
  property p_blk;
    cpu_ack && !cpu_grant |-> int_req && cpu_paddr == 18'h00000;
  endproperty
  a_blk: assert property (p_blk) else $error("refusal not suppressed");
  property p_lvl;
    int_req |-> cpu_ack && int_level == 4'he;
  endproperty
  a_lvl: assert property (p_lvl) else $error("wrong level");
  property p_nolvl;
    !int_req |-> int_level == 4'h0;
  endproperty
  a_nolvl: assert property (p_nolvl) else $error("level without request");
endmodule // page_mmu_asserts

bind page_mmu page_mmu_asserts chk
(
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .cpu_req(cpu_req),
  .cpu_vaddr(cpu_vaddr),
  .cpu_ack(cpu_ack),
  .cpu_grant(cpu_grant),
  .cpu_paddr(cpu_paddr),
  .int_req(int_req),
  .int_level(int_level),
  .mem_mgmt_on_flag(mem_mgmt_on_flag)
);

//--- tb/cpu_model.sv
// CPU side model: issues one access and samples the answer.
// Assumes the unit answers on the edge after the request.
`timescale 1ns/10ps
module cpu_model
(
  // Clock
  input wire sys_clk,
  // Request
  output logic cpu_req,
  output logic [15:0] cpu_vaddr,
  output logic [1:0] cpu_acc_type,
  output logic cpu_priv_instr,
  // Answer
  input wire cpu_grant,
  input wire [17:0] cpu_paddr,
  input wire int_req
);
  initial
  begin
    cpu_req = 1'b0;
    cpu_vaddr = 16'h0000;
    cpu_acc_type = 2'h0;
    cpu_priv_instr = 1'b0;
  end
  task automatic access(input logic [15:0] v, input logic [1:0] t, input logic p,
                        output logic g, output logic [17:0] a, output logic i);
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_vaddr <= v;
    cpu_acc_type <= t;
    cpu_priv_instr <= p;
    @(posedge sys_clk);
    cpu_req <= 1'b0;
    // Idle address shows no stale value
    cpu_vaddr <= ~v;
    @(posedge sys_clk);
    g = cpu_grant;
    a = cpu_paddr;
    i = int_req;
  endtask
endmodule // cpu_model

//--- tb/test_paged_memory_ring_protection.sv
// Bench for page_mmu: bus tasks, CPU model, random traffic.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`include "page_mmu_regs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_paged_memory_ring_protection;
  logic sys_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, seed = 32'h170de74e;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, cpu_acc_type, cur_ring_out;
  wire [31:0] s_axi_rdata;
  wire cpu_req, cpu_priv_instr, cpu_ack, cpu_grant, int_req, mem_mgmt_on_flag;
  wire [15:0] cpu_vaddr;
  wire [17:0] cpu_paddr;
  wire [3:0] int_level;
  logic [1:0] r, b;
  logic [31:0] d;
  int n_checks = 0, fails = 0;
  page_mmu DUT
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cpu_req(cpu_req),
    .cpu_vaddr(cpu_vaddr),
    .cpu_acc_type(cpu_acc_type),
    .cpu_priv_instr(cpu_priv_instr),
    .cpu_ack(cpu_ack),
    .cpu_grant(cpu_grant),
    .cpu_paddr(cpu_paddr),
    .int_req(int_req),
    .int_level(int_level),
    .cur_ring_out(cur_ring_out),
    .mem_mgmt_on_flag(mem_mgmt_on_flag)
  );
  cpu_model cpu
  (
    .sys_clk(sys_clk),
    .cpu_req(cpu_req),
    .cpu_vaddr(cpu_vaddr),
    .cpu_acc_type(cpu_acc_type),
    .cpu_priv_instr(cpu_priv_instr),
    .cpu_grant(cpu_grant),
    .cpu_paddr(cpu_paddr),
    .int_req(int_req)
  );
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] pte(input logic [2:0] wrf, input logic [1:0] rg,
                                      input logic [7:0] pg);
    return {wrf, 2'b00, rg, 1'b0, pg};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    b = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [15:0] e);
    rd(a);
    `CHK(d[15:0], e)
    if (a == `MMU_VIOL_OFF && e != 16'h0) wr(`MMU_VIOL_OFF, 16'h0000);
  endtask
  task automatic acc(input logic [15:0] v, input logic [1:0] t, input logic p,
                     input logic eg, input logic [7:0] pg);
    logic g, i;
    logic [17:0] a;
    cpu.access(v, t, p, g, a, i);
    `CHK(g, eg)
    `CHK(a, eg ? {pg, v[9:0]} : 18'h00000)
    `CHK(i, ~eg)
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    $display("unexpected at %0t: timeout", $time);
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(`MMU_CTRL_OFF, `STATUS_RESET);
    rd(12'h020);
    `CHK(r, 2'h2)
    wr(12'h020, 16'h1234);
    `CHK(b, 2'h2)
    repeat (8)
    begin
      seed = lfsr(seed);
      acc(seed[15:0], seed[17:16] % 2'h3, seed[18], 1'b1, {2'h0, seed[15:10]});
    end
    wr(`MMU_PT_BASE + 12'h108, pte(3'b011, 2'h3, 8'h5a)); // Table 1, page 2
    wr(`MMU_PT_BASE + 12'h114, pte(3'b010, 2'h2, 8'hc3));
    wr(`MMU_PT_BASE + 12'h11c, pte(3'b111, 2'h0, 8'h81));
    wr(`MMU_PT_BASE + 12'h008, pte(3'b011, 2'h3, 8'h11));
    rchk(`MMU_PT_BASE + 12'h114, pte(3'b010, 2'h2, 8'hc3));
    wr(`MMU_TSEL_OFF, 16'h0001);
    `CHK(b, 2'h0)
    s_axi_wstrb <= 4'h2;
    wr(`MMU_TSEL_OFF, 16'h0302);
    s_axi_wstrb <= 4'hf;
    rchk(`MMU_TSEL_OFF, 16'h0001);
    wr(`MMU_CTRL_OFF, 16'h4000);
    rchk(`MMU_CTRL_OFF, 16'h4000);
    `CHK(mem_mgmt_on_flag, 1'b1)
    acc(16'h0bff, `ACC_FETCH, 1'b0, 1'b1, 8'h5a);
    rchk(`MMU_RING_OFF, 16'h0003);
    `CHK(cur_ring_out, 2'h3)
    acc(16'h1401, `ACC_READ, 1'b1, 1'b1, 8'hc3);
    acc(16'h1402, `ACC_WRITE, 1'b0, 1'b0, 8'hc3);
    rchk(`MMU_VIOL_OFF, 16'h0002);
    rchk(`MMU_VIOL_OFF, 16'h0000);
    acc(16'h1c00, `ACC_FETCH, 1'b0, 1'b1, 8'h81);
    rchk(`MMU_RING_OFF, 16'h0000);
    `CHK(cur_ring_out, 2'h0)
    acc(16'h1433, `ACC_READ, 1'b0, 1'b0, 8'hc3);
    rchk(`MMU_VIOL_OFF, 16'h0008);
    rchk(`MMU_VADDR_OFF, 16'h1433);
    acc(16'h1d00, `ACC_READ, 1'b1, 1'b0, 8'h81);
    rchk(`MMU_VIOL_OFF, 16'h0010);
    acc(16'h1500, `ACC_FETCH, 1'b0, 1'b0, 8'hc3);
    rchk(`MMU_VIOL_OFF, 16'h0004);
    for (int m = 0; m < 8; m++)
    begin
      seed = lfsr(seed);
      wr(`MMU_PT_BASE + 12'h124, pte(m[2:0], 2'h0, seed[7:0]));
      acc({6'h09, seed[9:0]}, `ACC_READ, 1'b0, m[1], seed[7:0]);
      acc({6'h09, seed[9:0]}, `ACC_WRITE, 1'b0, m[2], seed[7:0]);
      acc({6'h09, seed[9:0]}, `ACC_FETCH, 1'b0, m[0], seed[7:0]);
    end
    wr(`MMU_CTRL_OFF, 16'h0000);
    rchk(`MMU_CTRL_OFF, 16'h0000);
    acc(16'h1402, `ACC_WRITE, 1'b1, 1'b1, 8'h05);
    // Mid-run reset with management on must clear status and tables
    wr(`MMU_CTRL_OFF, 16'h4000);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(`MMU_CTRL_OFF, `STATUS_RESET);
    `CHK(mem_mgmt_on_flag, 1'b0)
    rchk(`MMU_PT_BASE + 12'h114, `PTE_RESET);
    tally_and_finish();
  end
endmodule // test_paged_memory_ring_protection
